// *** src/gfp_params.svh ***
// Constants of the port data and fan PWM register slice
// Function
// [R01] Port 1 data bits 0-7, reset 00
// [R02] Port 2 data; bit 3 reserved, no pin
// [R03] Port 3 bits 2,3 also clear on main resets
// [R04] Port 4 data bits 0-3; 7:4 reserved
// [R05] Port 5 bit 3 also clears on main resets
// [R06] Port 6 data bits 0-1; 7:2 reserved
// [R07] Offsets 51 to 55 read zero
// [R08] Fan one: bit0 forces high, else PWM
// [R09] Fan two: bit0 forces high, else PWM
// [R10] Duty 0 low, 32 half, 63 is 63:1
// [R11] Fan one bit 7 selects its frequency
// [R12] Fan two bit 7 selects its frequency
// [R13] Control bit 2 doubles fan one frequency
// [R14] Control bit 3 doubles fan two frequency
// [R15] Multiplier one doubles, zero leaves speed
// [R16] PWM period is 64 slots, duty high
// [R17] Input pins read level; writes drive outputs
`ifndef GFP_PARAMS_SVH
`define GFP_PARAMS_SVH

// ----------------------------------------------------------------
// Register indices (byte address is four times the index)
// ----------------------------------------------------------------
`define GFP_IDX_PORT1 7'h4B
`define GFP_IDX_PORT2 7'h4C
`define GFP_IDX_PORT3 7'h4D
`define GFP_IDX_PORT4 7'h4E
`define GFP_IDX_PORT5 7'h4F
`define GFP_IDX_PORT6 7'h50
`define GFP_IDX_RSVD_LO 7'h51
`define GFP_IDX_RSVD_HI 7'h55
`define GFP_IDX_FAN_ONE 7'h56
`define GFP_IDX_FAN_TWO 7'h57
`define GFP_IDX_FAN_CTRL 7'h58

// ----------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------
`define GFP_RST_PORT 8'h00
`define GFP_RST_FAN 8'h00
`define GFP_RST_FAN_CTRL 8'h50

// ----------------------------------------------------------------
// Pin masks and main-reset clear masks per port
// ----------------------------------------------------------------
`define GFP_MASK_PORT1 8'hFF
`define GFP_MASK_PORT2 8'hF7
`define GFP_MASK_PORT3 8'hFF
`define GFP_MASK_PORT4 8'h0F
`define GFP_MASK_PORT5 8'hFF
`define GFP_MASK_PORT6 8'h03
`define GFP_CLR_NONE 8'h00
`define GFP_CLR_PORT3 8'h0C
`define GFP_CLR_PORT5 8'h08

// ----------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------
`define GFP_FAN_FORCE_BIT 0
`define GFP_FAN_DUTY_LSB 1
`define GFP_FAN_DUTY_MSB 6
`define GFP_FAN_CLKSEL_BIT 7
`define GFP_CTRL_SRC_ONE_BIT 0
`define GFP_CTRL_SRC_TWO_BIT 1
`define GFP_CTRL_DBL_ONE_BIT 2
`define GFP_CTRL_DBL_TWO_BIT 3

// ----------------------------------------------------------------
// Slot divider defaults, indexed by {source, clock select}
// ----------------------------------------------------------------
`define GFP_DIV_00 16'h0400
`define GFP_DIV_01 16'h0200
`define GFP_DIV_10 16'h0100
`define GFP_DIV_11 16'h0080

`endif

// *** src/gfp_pkg.sv ***
// Types shared by the register slice and its sub-blocks
package gfp_pkg;

  // ----------------------------------------------------------------
  // Pin carriers
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [7:0] dir_in;
    logic [7:0] level;
  } gfp_pin_in_t;

  typedef struct packed {
    logic [7:0] drive;
    logic [7:0] oe;
  } gfp_pin_out_t;

  // ----------------------------------------------------------------
  // Fan setting carrier
  // ----------------------------------------------------------------
  typedef struct packed {
    logic force_hi;
    logic [5:0] duty;
    logic [1:0] div_sel;
    logic dbl;
  } gfp_fan_cfg_t;

  // ----------------------------------------------------------------
  // Bus answer states
  // ----------------------------------------------------------------
  typedef enum logic [0:0] {
    GFP_IDLE = 1'b0,
    GFP_ACK = 1'b1
  } gfp_bus_state_t;

endpackage : gfp_pkg

// *** src/gfp_port.sv ***
// One eight-bit port data register with its pins
`include "gfp_params.svh"

module gfp_port #(
  parameter logic [7:0] PIN_MASK = 8'hFF,
  parameter logic [7:0] MAIN_CLR = 8'h00
) (
  // Clock and resets
  input wire logic core_clk,
  input wire logic rstn,
  input wire logic main_clr,
  // Register access
  input wire logic wr_en,
  input wire logic [7:0] wdata,
  output logic [7:0] rdata,
  // Pins
  input wire gfp_pkg::gfp_pin_in_t pins_in,
  output gfp_pkg::gfp_pin_out_t pins_out
);
  import gfp_pkg::*;

  logic [7:0] data_q;
  logic [7:0] data_d;
  logic [7:0] drive_q;
  logic [7:0] oe_q;
  logic [7:0] oe_d;
  logic [7:0] sense;

  // ----------------------------------------------------------------
  // Next value: write, then main-supply or host-bus clear
  // ----------------------------------------------------------------
  wire logic [7:0] written = wr_en ? (wdata & PIN_MASK) : data_q;
  assign data_d = main_clr ? (written & ~MAIN_CLR) : written; // [R03] [R05]
  assign oe_d = ~pins_in.dir_in & PIN_MASK; // [R02] [R04] [R06]

  // Input pins read their level, output pins read the latch
  assign sense = (pins_in.dir_in & pins_in.level) | (~pins_in.dir_in & data_q); // [R17]
  assign rdata = sense & PIN_MASK; // [R02] [R04] [R06]
  assign pins_out.drive = drive_q;
  assign pins_out.oe = oe_q;

  // ----------------------------------------------------------------
  // Registers, standby power-on reset
  // ----------------------------------------------------------------
  always_ff @(posedge core_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      data_q <= `GFP_RST_PORT; // [R01]
      drive_q <= 8'h00;
      oe_q <= 8'h00;
    end
    else
    begin
      data_q <= data_d;
      drive_q <= data_d & PIN_MASK; // [R17]
      oe_q <= oe_d;
    end
  end

endmodule : gfp_port

// *** src/gfp_pwm.sv ***
// Sixty-four slot fan PWM generator
`include "gfp_params.svh"

module gfp_pwm #(
  parameter logic [15:0] DIV_00 = `GFP_DIV_00,
  parameter logic [15:0] DIV_01 = `GFP_DIV_01,
  parameter logic [15:0] DIV_10 = `GFP_DIV_10,
  parameter logic [15:0] DIV_11 = `GFP_DIV_11
) (
  // Clock and reset
  input wire logic core_clk,
  input wire logic rstn,
  // Setting
  input wire gfp_pkg::gfp_fan_cfg_t cfg,
  // Fan pin
  output logic fan_out
);
  import gfp_pkg::*;

  logic [15:0] tick_q;
  logic [15:0] tick_d;
  logic [5:0] slot_q;
  logic [5:0] slot_d;
  logic out_q;
  logic out_d;

  // ----------------------------------------------------------------
  // Slot length from source, clock select and multiplier
  // ----------------------------------------------------------------
  wire logic [15:0] base = (cfg.div_sel == 2'b00) ? DIV_00 :
                           (cfg.div_sel == 2'b01) ? DIV_01 :
                           (cfg.div_sel == 2'b10) ? DIV_10 : DIV_11; // [R11] [R12]
  wire logic [15:0] slot_len = cfg.dbl ? {1'b0, base[15:1]} : base; // [R13] [R14] [R15]
  wire logic slot_end = (tick_q >= slot_len - 16'h0001);

  assign tick_d = slot_end ? 16'h0000 : tick_q + 16'h0001;
  assign slot_d = slot_end ? slot_q + 6'h01 : slot_q; // [R16]
  // High while the slot is below the duty count: 0 never, 63 leaves one low
  assign out_d = cfg.force_hi | (slot_d < cfg.duty); // [R08] [R09] [R10] [R16]
  assign fan_out = out_q;

  always_ff @(posedge core_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      tick_q <= 16'h0000;
      slot_q <= 6'h00;
      out_q <= 1'b0;
    end
    else
    begin
      tick_q <= tick_d;
      slot_q <= slot_d;
      out_q <= out_d;
    end
  end

endmodule : gfp_pwm

// *** src/gfp_regs.sv ***
// Port data and fan PWM register slice with Avalon-MM slave
//
// Decided for this implementation: the Avalon-MM register port.
`include "gfp_params.svh"

module gfp_regs #(
  parameter logic [15:0] DIV_00 = `GFP_DIV_00,
  parameter logic [15:0] DIV_01 = `GFP_DIV_01,
  parameter logic [15:0] DIV_10 = `GFP_DIV_10,
  parameter logic [15:0] DIV_11 = `GFP_DIV_11
) (
  // Clock and standby power-on reset
  input wire logic core_clk,
  input wire logic rstn,
  // Main-supply power-on reset and host bus reset
  input wire logic main_por_n,
  input wire logic host_bus_rst_n,
  // Avalon-MM slave
  input wire logic [8:0] address,
  input wire logic read,
  input wire logic write,
  input wire logic [31:0] writedata,
  input wire logic [3:0] byteenable,
  output logic [31:0] readdata,
  output logic waitrequest,
  // Port pins
  input wire gfp_pkg::gfp_pin_in_t port1_pins_in,
  input wire gfp_pkg::gfp_pin_in_t port2_pins_in,
  input wire gfp_pkg::gfp_pin_in_t port3_pins_in,
  input wire gfp_pkg::gfp_pin_in_t port4_pins_in,
  input wire gfp_pkg::gfp_pin_in_t port5_pins_in,
  input wire gfp_pkg::gfp_pin_in_t port6_pins_in,
  output gfp_pkg::gfp_pin_out_t port1_pins_out,
  output gfp_pkg::gfp_pin_out_t port2_pins_out,
  output gfp_pkg::gfp_pin_out_t port3_pins_out,
  output gfp_pkg::gfp_pin_out_t port4_pins_out,
  output gfp_pkg::gfp_pin_out_t port5_pins_out,
  output gfp_pkg::gfp_pin_out_t port6_pins_out,
  // Fan pins
  output logic fan_one_output,
  output logic fan_two_output
);
  import gfp_pkg::*;

  // ----------------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------------
  gfp_bus_state_t state_q;
  gfp_bus_state_t state_d;
  logic waitrequest_q;
  logic waitrequest_d;
  logic [31:0] readdata_q;
  logic [31:0] readdata_d;
  logic [7:0] fan_one_q;
  logic [7:0] fan_one_d;
  logic [7:0] fan_two_q;
  logic [7:0] fan_two_d;
  logic [7:0] fan_ctrl_q;
  logic [7:0] fan_ctrl_d;
  logic [7:0] rd_port1;
  logic [7:0] rd_port2;
  logic [7:0] rd_port3;
  logic [7:0] rd_port4;
  logic [7:0] rd_port5;
  logic [7:0] rd_port6;
  logic [7:0] rd_byte;
  gfp_fan_cfg_t fan_one_cfg;
  gfp_fan_cfg_t fan_two_cfg;

  // ----------------------------------------------------------------
  // Address decode
  // ----------------------------------------------------------------
  wire logic [6:0] idx = address[8:2];
  wire logic req = read | write;
  // A write lands at the edge where waitrequest is seen low
  wire logic commit = (state_q == GFP_ACK) & write & byteenable[0];
  wire logic hit_port1 = (idx == `GFP_IDX_PORT1);
  wire logic hit_port2 = (idx == `GFP_IDX_PORT2);
  wire logic hit_port3 = (idx == `GFP_IDX_PORT3);
  wire logic hit_port4 = (idx == `GFP_IDX_PORT4);
  wire logic hit_port5 = (idx == `GFP_IDX_PORT5);
  wire logic hit_port6 = (idx == `GFP_IDX_PORT6);
  wire logic hit_fan_one = (idx == `GFP_IDX_FAN_ONE);
  wire logic hit_fan_two = (idx == `GFP_IDX_FAN_TWO);
  wire logic hit_fan_ctrl = (idx == `GFP_IDX_FAN_CTRL);
  wire logic wr_port1 = commit & hit_port1;
  wire logic wr_port2 = commit & hit_port2;
  wire logic wr_port3 = commit & hit_port3;
  wire logic wr_port4 = commit & hit_port4;
  wire logic wr_port5 = commit & hit_port5;
  wire logic wr_port6 = commit & hit_port6;
  wire logic [7:0] wbyte = writedata[7:0];

  // Main-supply and host bus resets clear selected port bits
  wire logic main_clr = ~main_por_n | ~host_bus_rst_n; // [R03] [R05]

  // ----------------------------------------------------------------
  // Read multiplexer; reserved and unmapped offsets read zero
  // ----------------------------------------------------------------
  assign rd_byte = hit_port1 ? rd_port1 :
                   hit_port2 ? rd_port2 :
                   hit_port3 ? rd_port3 :
                   hit_port4 ? rd_port4 :
                   hit_port5 ? rd_port5 :
                   hit_port6 ? rd_port6 :
                   hit_fan_one ? fan_one_q :
                   hit_fan_two ? fan_two_q :
                   hit_fan_ctrl ? fan_ctrl_q : 8'h00; // [R07]
  assign readdata_d = (state_q == GFP_IDLE && read) ? {24'h000000, rd_byte} : readdata_q;

  // ----------------------------------------------------------------
  // Bus answer: one wait cycle, then a single ready cycle
  // ----------------------------------------------------------------
  always_comb
  begin
    case (state_q)
      GFP_IDLE:
      begin
        state_d = req ? GFP_ACK : GFP_IDLE;
      end
      GFP_ACK:
      begin
        state_d = GFP_IDLE;
      end
      default:
      begin
        state_d = GFP_IDLE;
      end
    endcase
  end

  // Registered so the answer leaves a flip-flop directly
  assign waitrequest_d = (state_d != GFP_ACK);
  assign waitrequest = waitrequest_q;
  assign readdata = readdata_q;

  always_ff @(posedge core_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      state_q <= GFP_IDLE;
      waitrequest_q <= 1'b1;
      readdata_q <= 32'h00000000;
    end
    else
    begin
      state_q <= state_d;
      waitrequest_q <= waitrequest_d;
      readdata_q <= readdata_d;
    end
  end

  // ----------------------------------------------------------------
  // Fan registers
  // ----------------------------------------------------------------
  assign fan_one_d = (commit & hit_fan_one) ? wbyte : fan_one_q;
  assign fan_two_d = (commit & hit_fan_two) ? wbyte : fan_two_q;
  assign fan_ctrl_d = (commit & hit_fan_ctrl) ? wbyte : fan_ctrl_q;

  always_ff @(posedge core_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      fan_one_q <= `GFP_RST_FAN;
      fan_two_q <= `GFP_RST_FAN;
      fan_ctrl_q <= `GFP_RST_FAN_CTRL;
    end
    else
    begin
      fan_one_q <= fan_one_d;
      fan_two_q <= fan_two_d;
      fan_ctrl_q <= fan_ctrl_d;
    end
  end

  // ----------------------------------------------------------------
  // Fan settings
  // ----------------------------------------------------------------
  assign fan_one_cfg.force_hi = fan_one_q[`GFP_FAN_FORCE_BIT]; // [R08]
  assign fan_one_cfg.duty = fan_one_q[`GFP_FAN_DUTY_MSB:`GFP_FAN_DUTY_LSB]; // [R08]
  assign fan_one_cfg.div_sel = {fan_ctrl_q[`GFP_CTRL_SRC_ONE_BIT],
                                fan_one_q[`GFP_FAN_CLKSEL_BIT]}; // [R11]
  assign fan_one_cfg.dbl = fan_ctrl_q[`GFP_CTRL_DBL_ONE_BIT]; // [R13] [R15]
  assign fan_two_cfg.force_hi = fan_two_q[`GFP_FAN_FORCE_BIT]; // [R09]
  assign fan_two_cfg.duty = fan_two_q[`GFP_FAN_DUTY_MSB:`GFP_FAN_DUTY_LSB]; // [R09]
  assign fan_two_cfg.div_sel = {fan_ctrl_q[`GFP_CTRL_SRC_TWO_BIT],
                                fan_two_q[`GFP_FAN_CLKSEL_BIT]}; // [R12]
  assign fan_two_cfg.dbl = fan_ctrl_q[`GFP_CTRL_DBL_TWO_BIT]; // [R14]

  // ----------------------------------------------------------------
  // Fan generators
  // ----------------------------------------------------------------
  gfp_pwm #(
    .DIV_00(DIV_00),
    .DIV_01(DIV_01),
    .DIV_10(DIV_10),
    .DIV_11(DIV_11)
  ) u_fan_one (
    .core_clk(core_clk),
    .rstn(rstn),
    .cfg(fan_one_cfg),
    .fan_out(fan_one_output)
  );

  gfp_pwm #(
    .DIV_00(DIV_00),
    .DIV_01(DIV_01),
    .DIV_10(DIV_10),
    .DIV_11(DIV_11)
  ) u_fan_two (
    .core_clk(core_clk),
    .rstn(rstn),
    .cfg(fan_two_cfg),
    .fan_out(fan_two_output)
  );

  // ----------------------------------------------------------------
  // Port data registers
  // ----------------------------------------------------------------
  gfp_port #(
    .PIN_MASK(`GFP_MASK_PORT1),
    .MAIN_CLR(`GFP_CLR_NONE)
  ) u_port1 (
    .core_clk(core_clk),
    .rstn(rstn),
    .main_clr(main_clr),
    .wr_en(wr_port1), // [R01]
    .wdata(wbyte),
    .rdata(rd_port1),
    .pins_in(port1_pins_in),
    .pins_out(port1_pins_out)
  );

  gfp_port #(
    .PIN_MASK(`GFP_MASK_PORT2),
    .MAIN_CLR(`GFP_CLR_NONE)
  ) u_port2 (
    .core_clk(core_clk),
    .rstn(rstn),
    .main_clr(main_clr),
    .wr_en(wr_port2), // [R02]
    .wdata(wbyte),
    .rdata(rd_port2),
    .pins_in(port2_pins_in),
    .pins_out(port2_pins_out)
  );

  gfp_port #(
    .PIN_MASK(`GFP_MASK_PORT3),
    .MAIN_CLR(`GFP_CLR_PORT3)
  ) u_port3 (
    .core_clk(core_clk),
    .rstn(rstn),
    .main_clr(main_clr),
    .wr_en(wr_port3), // [R03]
    .wdata(wbyte),
    .rdata(rd_port3),
    .pins_in(port3_pins_in),
    .pins_out(port3_pins_out)
  );

  gfp_port #(
    .PIN_MASK(`GFP_MASK_PORT4),
    .MAIN_CLR(`GFP_CLR_NONE)
  ) u_port4 (
    .core_clk(core_clk),
    .rstn(rstn),
    .main_clr(main_clr),
    .wr_en(wr_port4), // [R04]
    .wdata(wbyte),
    .rdata(rd_port4),
    .pins_in(port4_pins_in),
    .pins_out(port4_pins_out)
  );

  gfp_port #(
    .PIN_MASK(`GFP_MASK_PORT5),
    .MAIN_CLR(`GFP_CLR_PORT5)
  ) u_port5 (
    .core_clk(core_clk),
    .rstn(rstn),
    .main_clr(main_clr),
    .wr_en(wr_port5), // [R05]
    .wdata(wbyte),
    .rdata(rd_port5),
    .pins_in(port5_pins_in),
    .pins_out(port5_pins_out)
  );

  gfp_port #(
    .PIN_MASK(`GFP_MASK_PORT6),
    .MAIN_CLR(`GFP_CLR_NONE)
  ) u_port6 (
    .core_clk(core_clk),
    .rstn(rstn),
    .main_clr(main_clr),
    .wr_en(wr_port6), // [R06]
    .wdata(wbyte),
    .rdata(rd_port6),
    .pins_in(port6_pins_in),
    .pins_out(port6_pins_out)
  );

endmodule : gfp_regs

// *** verif/gfp_regs_chk.sv ***
// Concurrent checks on the ports of the register slice
module gfp_regs_chk (
  // Clock and resets
  input wire logic core_clk,
  input wire logic rstn,
  input wire logic main_por_n,
  input wire logic host_bus_rst_n,
  // Register bus
  input wire logic [8:0] address,
  input wire logic read,
  input wire logic write,
  input wire logic [31:0] writedata,
  input wire logic [3:0] byteenable,
  input wire logic [31:0] readdata,
  input wire logic waitrequest,
  // Pins
  input wire gfp_pkg::gfp_pin_in_t port1_pins_in,
  input wire gfp_pkg::gfp_pin_out_t port1_pins_out,
  input wire gfp_pkg::gfp_pin_out_t port2_pins_out,
  input wire gfp_pkg::gfp_pin_out_t port3_pins_out,
  input wire gfp_pkg::gfp_pin_out_t port4_pins_out,
  input wire gfp_pkg::gfp_pin_out_t port5_pins_out,
  input wire gfp_pkg::gfp_pin_out_t port6_pins_out,
  input wire logic fan_one_output
);
  import gfp_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;

  // ---------------------------------------------------------------
  // Write commits seen on the bus
  // ---------------------------------------------------------------
  wire logic wr_done = write && !waitrequest && byteenable[0];
  wire logic p1_commit = wr_done && address[8:2] == 7'h4B;
  wire logic f1_commit = wr_done && address[8:2] == 7'h56;
  logic [7:0] p1_wval_q;

  always_ff @(posedge core_clk or negedge rstn)
  begin
    if (!rstn)
      p1_wval_q <= 8'h00;
    else if (p1_commit)
      p1_wval_q <= writedata[7:0];
  end

  // ---------------------------------------------------------------
  // Assertions
  // ---------------------------------------------------------------
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rstn);

  chk_answer_next: assert property ((read || write) && waitrequest |=> !waitrequest)
    else $error("request not answered in the next cycle");
  chk_answer_single: assert property (!waitrequest |=> waitrequest)
    else $error("answer lasted more than one cycle");
  chk_read_upper: assert property (!waitrequest |-> readdata[31:8] == 24'h000000)
    else $error("upper read lanes not zero");
  chk_port2_rsvd: assert property (!port2_pins_out.oe[3] && !port2_pins_out.drive[3])
    else $error("reserved pin of port 2 driven");
  chk_port4_rsvd: assert property (port4_pins_out.oe[7:4] == 4'h0)
    else $error("reserved pins of port 4 enabled");
  chk_port6_rsvd: assert property (port6_pins_out.oe[7:2] == 6'h00)
    else $error("reserved pins of port 6 enabled");
  chk_dir_follow: assert property ($past(rstn) |-> port1_pins_out.oe == ~$past(port1_pins_in.dir_in))
    else $error("port 1 enables do not follow direction");
  chk_p1_drive: assert property (p1_commit |-> ##[1:2] port1_pins_out.drive == p1_wval_q)
    else $error("port 1 drive differs from written value");
  chk_main_clear: assert property ((!main_por_n || !host_bus_rst_n) |-> ##2
    (port3_pins_out.drive[3:2] == 2'h0 && !port5_pins_out.drive[3]))
    else $error("main reset did not clear port bits");
  chk_force_high: assert property (f1_commit && writedata[0] |-> ##[1:3] fan_one_output)
    else $error("fan one not forced high");
  chk_duty_zero: assert property (f1_commit && writedata[6:0] == 7'h00 |-> ##4 (!fan_one_output) [*8])
    else $error("fan one not low at zero duty");

  cov_read: cover property (read && !waitrequest);
  cov_force: cover property (f1_commit && writedata[0]);
  cov_main: cover property (!main_por_n);
  cov_host: cover property (!host_bus_rst_n);
endmodule : gfp_regs_chk

// *** verif/testbench.sv ***
// Self-checking bench for the port data and fan PWM register slice
module testbench
  import gfp_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;

  logic core_clk, rstn, main_por_n, host_bus_rst_n;
  logic [8:0] address;
  logic read, write;
  logic [31:0] writedata, readdata;
  logic [3:0] byteenable;
  logic waitrequest, fan_one_output, fan_two_output;
  gfp_pin_in_t pin_in [6];
  gfp_pin_out_t pin_out [6];
  int n_mismatch, checks;
  localparam logic [7:0] PORT_MASK [6] = '{8'hFF, 8'hF7, 8'hFF, 8'h0F, 8'hFF, 8'h03};

  // ---------------------------------------------------------------
  // Clock and device
  // ---------------------------------------------------------------
  initial
  begin
    core_clk = 1'b0;
    forever #5 core_clk = ~core_clk;
  end

  gfp_regs #(.DIV_00(16'h0008), .DIV_01(16'h0006), .DIV_10(16'h0004), .DIV_11(16'h0002))
    i_gfp_regs (
    .core_clk(core_clk), .rstn(rstn), .main_por_n(main_por_n),
    .host_bus_rst_n(host_bus_rst_n), .address(address), .read(read), .write(write),
    .writedata(writedata), .byteenable(byteenable), .readdata(readdata),
    .waitrequest(waitrequest), .port1_pins_in(pin_in[0]), .port2_pins_in(pin_in[1]),
    .port3_pins_in(pin_in[2]), .port4_pins_in(pin_in[3]), .port5_pins_in(pin_in[4]),
    .port6_pins_in(pin_in[5]), .port1_pins_out(pin_out[0]), .port2_pins_out(pin_out[1]),
    .port3_pins_out(pin_out[2]), .port4_pins_out(pin_out[3]), .port5_pins_out(pin_out[4]),
    .port6_pins_out(pin_out[5]), .fan_one_output(fan_one_output),
    .fan_two_output(fan_two_output));

  // ---------------------------------------------------------------
  // Shared tasks
  // ---------------------------------------------------------------
  task automatic summarize;
    $display("Checks %0d mismatches %0d", checks, n_mismatch);
    if (n_mismatch == 0 && checks > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask : summarize

  task automatic compare(input string what, input logic [31:0] exp, input logic [31:0] got);
    checks++;
    if (got !== exp)
    begin
      n_mismatch++;
      $display("ERROR %s expected %0h seen %0h", what, exp, got);
    end
  endtask : compare

  task automatic bus(input logic [6:0] idx, input logic wr, input logic [7:0] wd,
                     input logic [3:0] be, output logic [31:0] rd);
    int n;
    @(posedge core_clk);
    address <= {idx, 2'b00};
    read <= ~wr;
    write <= wr;
    writedata <= {24'h000000, wd};
    byteenable <= be;
    n = 0;
    do
    begin
      @(posedge core_clk);
      n++;
    end
    while (waitrequest !== 1'b0 && n < 50);
    rd = readdata;
    read <= 1'b0;
    write <= 1'b0;
    if (n >= 50)
    begin
      n_mismatch++;
      $display("ERROR waitrequest expected 0 seen %b", waitrequest);
      summarize();
    end
  endtask : bus

  task automatic wr(input logic [6:0] idx, input logic [7:0] d);
    logic [31:0] rd;
    bus(idx, 1'b1, d, 4'h1, rd);
  endtask : wr

  task automatic rd_chk(input logic [6:0] idx, input logic [7:0] exp);
    logic [31:0] rd;
    bus(idx, 1'b0, 8'h00, 4'h1, rd);
    compare($sformatf("register %0h", idx), {24'h000000, exp}, rd);
  endtask : rd_chk

  // ---------------------------------------------------------------
  // Scenarios
  // ---------------------------------------------------------------
  task automatic port_case(input int i);
    logic [6:0] idx;
    logic [31:0] rd;
    idx = 7'(7'h4B + i);
    wr(idx, 8'hFF);
    rd_chk(idx, PORT_MASK[i]);
    compare("drive", {24'h0, PORT_MASK[i]}, {24'h0, pin_out[i].drive});
    compare("oe", {24'h0, PORT_MASK[i]}, {24'h0, pin_out[i].oe});
    bus(idx, 1'b1, 8'h3C, 4'h0, rd);
    rd_chk(idx, PORT_MASK[i]);
    pin_in[i] <= '{dir_in: 8'hFF, level: 8'h5A};
    rd_chk(idx, 8'h5A & PORT_MASK[i]);
    compare("oe", 32'h0, {24'h0, pin_out[i].oe});
    pin_in[i] <= '{dir_in: 8'h00, level: 8'h00};
    wr(idx, 8'h00);
  endtask : port_case

  task automatic clr_case(input int s);
    wr(7'h4B, 8'hFF);
    wr(7'h4D, 8'hFF);
    wr(7'h4F, 8'hFF);
    @(posedge core_clk);
    if (s == 0)
      main_por_n <= 1'b0;
    else
      host_bus_rst_n <= 1'b0;
    @(posedge core_clk);
    main_por_n <= 1'b1;
    host_bus_rst_n <= 1'b1;
    rd_chk(7'h4D, 8'hF3);
    rd_chk(7'h4F, 8'hF7);
    rd_chk(7'h4B, 8'hFF);
  endtask : clr_case

  // Counts high cycles and rising edges over whole periods after settling
  task automatic fan_case(input bit two, input logic [7:0] ctrl, input logic [7:0] fr,
                          input int win, input int exp_hi, input int exp_rise);
    int hi;
    int rises;
    logic prev;
    logic cur;
    wr(7'h58, ctrl);
    wr(two ? 7'h57 : 7'h56, fr);
    rd_chk(two ? 7'h57 : 7'h56, fr);
    repeat (1024) @(posedge core_clk);
    prev = two ? fan_two_output : fan_one_output;
    hi = 0;
    rises = 0;
    repeat (win)
    begin
      @(posedge core_clk);
      cur = two ? fan_two_output : fan_one_output;
      if (cur === 1'b1)
        hi++;
      if (cur === 1'b1 && prev === 1'b0)
        rises++;
      prev = cur;
    end
    compare("fan high cycles", exp_hi, hi);
    compare("fan rising edges", exp_rise, rises);
  endtask : fan_case

  initial
  begin
    rstn = 1'b0;
    main_por_n = 1'b1;
    host_bus_rst_n = 1'b1;
    address = 9'h000;
    read = 1'b0;
    write = 1'b0;
    writedata = 32'h00000000;
    byteenable = 4'h0;
    for (int i = 0; i < 6; i++)
      pin_in[i] = '0;
    n_mismatch = 0;
    checks = 0;
    repeat (16) @(posedge core_clk);
    rstn <= 1'b1;
    for (int i = 0; i < 6; i++)
      rd_chk(7'(7'h4B + i), 8'h00);
    rd_chk(7'h56, 8'h00);
    rd_chk(7'h57, 8'h00);
    rd_chk(7'h58, 8'h50);
    $display("Done reset values");
    for (int i = 0; i < 6; i++)
      port_case(i);
    $display("Done port data");
    for (int i = 0; i < 5; i++)
    begin
      wr(7'(7'h51 + i), 8'hFF);
      rd_chk(7'(7'h51 + i), 8'h00);
    end
    wr(7'h7F, 8'hFF);
    rd_chk(7'h7F, 8'h00);
    $display("Done reserved offsets");
    for (int s = 0; s < 2; s++)
      clr_case(s);
    $display("Done main resets");
    fan_case(1'b0, 8'h00, 8'h00, 512, 0, 0);
    fan_case(1'b0, 8'h00, 8'h40, 1024, 512, 2);
    fan_case(1'b0, 8'h00, 8'h7E, 1024, 1008, 2);
    fan_case(1'b0, 8'h00, 8'h01, 1024, 1024, 0);
    fan_case(1'b0, 8'h00, 8'hC0, 768, 384, 2);
    fan_case(1'b0, 8'h04, 8'hC0, 768, 384, 4);
    fan_case(1'b0, 8'h01, 8'h40, 768, 384, 3);
    fan_case(1'b1, 8'h00, 8'h02, 1024, 16, 2);
    fan_case(1'b1, 8'h00, 8'h01, 1024, 1024, 0);
    fan_case(1'b1, 8'h0A, 8'hC0, 768, 384, 12);
    $display("Done fan outputs");
    summarize();
  end
endmodule : testbench

bind gfp_regs gfp_regs_chk i_gfp_regs_chk (
  .core_clk(core_clk), .rstn(rstn), .main_por_n(main_por_n),
  .host_bus_rst_n(host_bus_rst_n), .address(address), .read(read), .write(write),
  .writedata(writedata), .byteenable(byteenable), .readdata(readdata),
  .waitrequest(waitrequest), .port1_pins_in(port1_pins_in),
  .port1_pins_out(port1_pins_out), .port2_pins_out(port2_pins_out),
  .port3_pins_out(port3_pins_out), .port4_pins_out(port4_pins_out),
  .port5_pins_out(port5_pins_out), .port6_pins_out(port6_pins_out),
  .fan_one_output(fan_one_output));
